// ### hw/psp_pkg.sv
package psp_pkg;
    // Register offsets on the plain register port
    localparam logic [1:0] OFS_PIN_STATE = 2'h0; // Pin-state, read only
    localparam logic [1:0] OFS_DIRECTION = 2'h1; // Direction, write only
    localparam logic [1:0] OFS_LATCH = 2'h2; // Output latch, read/write
    localparam logic [1:0] OFS_CONTROL = 2'h3; // Mode and enables
    // Control field positions
    localparam int CTL_MANUAL_RESET_IN_EN = 0; // Manual reset enable
    localparam int CTL_DBG_EN = 1; // Debug port enable
    localparam int CTL_MODE_LO = 2; // Operating mode, 3 bits
    // Reset values
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [2:0] MODE_RESET = 3'h7;
    localparam logic [7:0] RSVD_READ = 8'h00; // Undefined bits read as zero
    // Implemented-bit masks per variant
    localparam logic [7:0] MASK_BUSCTL = 8'h13; // Bits 4, 1, 0
    localparam logic [7:0] MASK_DEBUG = 8'he0; // Bits 7, 6, 5
    // Pin positions
    localparam int PIN_CS4 = 0;
    localparam int PIN_CS5 = 1;
    localparam int PIN_MANUAL_RESET_IN = 4;
    localparam int PIN_TMS = 5;
    localparam int PIN_TCK = 6;
    localparam int PIN_TDO = 7;
    // Mode that turns chip selects off, and lowest mode that turns them on
    localparam logic [2:0] MODE_SINGLE = 3'h7;
    localparam logic [2:0] MODE_EXT_LO = 3'h4;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } psp_bus_type;

    // Special functions delivered to the pins
    typedef struct packed {
        logic cs5;
        logic cs4;
        logic tdo;
    } psp_func_type;
endpackage

// ### hw/psp_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a bus of pin levels
module psp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // Both stages in one packed state
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } psp_sync_state_type;

    psp_sync_state_type state; // Registered stages
    psp_sync_state_type next_state; // Next stages

    // Shift one stage per edge; only the second stage reads the first
    always_comb
    begin
        next_state.meta = d;
        next_state.q = state.meta;
    end

    // Register both stages
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign q = state.q;
endmodule

// ### hw/psp_port.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - Bus variant: bits 4,1,0 read latch or pin
// - Debug variant: bits 7-5 read latch or pin
// - Bits 3,2 reserved, read undefined, ignore writes
// - Other variant's bits reserved, undefined, unwritable
// - Pin-state reset follows live pin levels
// - Manual reset enable makes pin four reset input
// - Modes 4-6 drive chip selects on pins 1,0 whose direction bit is one
// - Debug enable makes pins 7-5 scan pins
// - Direction resets 0; one means output
// - Latch resets 0, readable, drives output pins
module psp_port #(
    parameter bit DEBUG_VARIANT = 1'b0 // 0 bus-control, 1 debug-port
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire psp_pkg::psp_bus_type BUS,
    output logic [7:0] RDATA,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE_N,
    input wire psp_pkg::psp_func_type FUNC_IN,
    output logic MANUAL_RESET_IN,
    output logic TEST_CLOCK,
    output logic TEST_MODE_SELECT,
    output logic CHIP_SELECT_FIVE_ON,
    output logic CHIP_SELECT_FOUR_ON
);
    import psp_pkg::*;

    // Bits this variant implements
    // Direction and latch writes and pin-state reads are masked with it; control is not
    localparam logic [7:0] IMPL = DEBUG_VARIANT ? MASK_DEBUG : MASK_BUSCTL;

    // Whole state of the port
    typedef struct packed {
        // Registers seen by software
        logic [7:0] port_seven_direction; // Write-only direction
        logic [7:0] port_seven_output_latch; // Output latch
        // Control fields
        logic manual_reset_enable;
        logic debug_port_enable;
        logic [2:0] mode;
        // Registered outputs
        logic [7:0] rdata;
        logic [7:0] pin_out;
        logic [7:0] pin_oe_n;
        logic manual_reset_in;
        logic tck;
        logic tms;
        logic cs5_on;
        logic cs4_on;
    } psp_state_type;

    psp_state_type state; // Registered state
    psp_state_type next_state; // Next state
    logic [7:0] pin_sync; // Synchronised pin levels
    logic [7:0] pin_state; // Readback value
    logic [7:0] drive; // Pins driven by the port
    logic [7:0] value; // Value put on driven pins
    logic cs_mode; // Chip selects available

    // Pin levels through two flops
    // Logic reads only the second stage, never the first
    psp_sync #(.WIDTH(8)) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .d(PIN_IN),
        .q(pin_sync)
    );

    // Next-state logic
    always_comb
    begin
        next_state = state;
        // Latch value where output, pin otherwise
        pin_state = (state.port_seven_direction & state.port_seven_output_latch)
            | (~state.port_seven_direction & pin_sync);
        // Reserved bits read as a fixed value
        pin_state = (pin_state & IMPL) | (RSVD_READ & ~IMPL);
        // Modes 0 to 3 behave like mode 7, no chip selects
        cs_mode = (state.mode >= MODE_EXT_LO) && (state.mode != MODE_SINGLE);
        // General pins follow direction and latch
        // Reserved pins never drive, so they cannot fight the board
        drive = state.port_seven_direction & IMPL;
        value = state.port_seven_output_latch;
        if (!DEBUG_VARIANT)
        begin
            // Manual reset overrides direction
            if (state.manual_reset_enable)
            begin
                drive[PIN_MANUAL_RESET_IN] = 1'b0;
            end
            // Chip selects take over pins 1 and 0 in modes 4 to 6
            if (cs_mode)
            begin
                value[PIN_CS5] = FUNC_IN.cs5;
                value[PIN_CS4] = FUNC_IN.cs4;
            end
        end
        else if (state.debug_port_enable)
        begin
            // Scan pins whatever the direction bits say
            // Test data out driven; test clock and mode select are inputs
            drive[PIN_TDO] = 1'b1;
            drive[PIN_TCK] = 1'b0;
            drive[PIN_TMS] = 1'b0;
            value[PIN_TDO] = FUNC_IN.tdo;
        end
        // Drive and enable registered so the pins never glitch
        next_state.pin_out = value & drive;
        next_state.pin_oe_n = ~drive;
        // Special inputs and chip-select flags, quiet unless selected
        next_state.manual_reset_in = 1'b0;
        next_state.tck = 1'b0;
        next_state.tms = 1'b0;
        next_state.cs5_on = 1'b0;
        next_state.cs4_on = 1'b0;
        if (!DEBUG_VARIANT)
        begin
            // Pin four level goes to the reset input only when enabled
            next_state.manual_reset_in = state.manual_reset_enable && pin_sync[PIN_MANUAL_RESET_IN];
            // Chip-select flags follow mode and direction
            next_state.cs5_on = cs_mode && state.port_seven_direction[PIN_CS5];
            next_state.cs4_on = cs_mode && state.port_seven_direction[PIN_CS4];
        end
        else if (state.debug_port_enable)
        begin
            // Scan inputs taken from the synchronised pins
            next_state.tck = pin_sync[PIN_TCK];
            next_state.tms = pin_sync[PIN_TMS];
        end
        // Register writes; reserved bits never change
        // The pin-state offset takes no write
        if (BUS.wr)
        begin
            case (BUS.addr)
                OFS_DIRECTION:
                begin
                    // Whole byte replaces the old setting
                    next_state.port_seven_direction = BUS.wdata & IMPL;
                end
                OFS_LATCH:
                begin
                    // Only implemented bits are kept
                    next_state.port_seven_output_latch = BUS.wdata & IMPL;
                end
                OFS_CONTROL:
                begin
                    // Mode and enables in one byte
                    next_state.manual_reset_enable = BUS.wdata[CTL_MANUAL_RESET_IN_EN];
                    next_state.debug_port_enable = BUS.wdata[CTL_DBG_EN];
                    next_state.mode = BUS.wdata[CTL_MODE_LO +: 3];
                end
                default:
                begin
                    next_state.mode = state.mode; // Pin-state is read only
                end
            endcase
        end
        // Read data for one cycle after the strobe
        next_state.rdata = 8'h00;
        if (BUS.rd)
        begin
            case (BUS.addr)
                OFS_PIN_STATE:
                begin
                    // Latch or synchronised pin per bit
                    next_state.rdata = pin_state;
                end
                OFS_LATCH:
                begin
                    // Latch as written, reserved bits zero
                    next_state.rdata = state.port_seven_output_latch;
                end
                OFS_CONTROL:
                begin
                    // Mode and enables as written
                    next_state.rdata = {3'h0, state.mode, state.debug_port_enable,
                        state.manual_reset_enable};
                end
                default:
                begin
                    next_state.rdata = 8'h00; // Direction reads zero
                end
            endcase
        end
    end

    // Register the state
    // Asynchronous reset releases every pin at once
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            // Pins released, latches and direction cleared
            state <= '0;
            state.port_seven_direction <= DIR_RESET;
            state.port_seven_output_latch <= LATCH_RESET;
            state.mode <= MODE_RESET;
            state.pin_oe_n <= 8'hff;
        end
        else
        begin
            // Take the next state
            state <= next_state;
        end
    end

    // Outputs straight from flops
    assign RDATA = state.rdata;
    // Pin drivers
    assign PIN_OUT = state.pin_out;
    assign PIN_OE_N = state.pin_oe_n;
    // Special-function levels
    assign MANUAL_RESET_IN = state.manual_reset_in;
    assign TEST_CLOCK = state.tck;
    assign TEST_MODE_SELECT = state.tms;
    assign CHIP_SELECT_FIVE_ON = state.cs5_on;
    assign CHIP_SELECT_FOUR_ON = state.cs4_on;
endmodule

// ### sim/psp_port_properties.sv
`timescale 1ns/1ns
// Port-level checks beside the pin port
module psp_port_properties
    import psp_pkg::*;
#(
    parameter bit DEBUG_VARIANT = 1'b0
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire psp_pkg::psp_bus_type BUS,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] PIN_IN,
    input wire logic [7:0] PIN_OUT,
    input wire logic [7:0] PIN_OE_N,
    input wire psp_pkg::psp_func_type FUNC_IN,
    input wire logic MANUAL_RESET_IN,
    input wire logic TEST_CLOCK,
    input wire logic TEST_MODE_SELECT,
    input wire logic CHIP_SELECT_FIVE_ON,
    input wire logic CHIP_SELECT_FOUR_ON
);
    // Bits implemented by this variant
    localparam logic [7:0] IMPL = DEBUG_VARIANT ? MASK_DEBUG : MASK_BUSCTL;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Inputs quiet long enough to cross the synchroniser
    sequence quiet_inputs;
        (!BUS.wr && PIN_OE_N == 8'hff && $stable(PIN_IN)) [*4];
    endsequence
    sequence pin_read;
        BUS.rd && BUS.addr == OFS_PIN_STATE;
    endsequence
    read_idle_a: assert property (!BUS.rd |=> RDATA == 8'h00)
        else $error("read data without a read");
    read_rsvd_a: assert property (BUS.rd && BUS.addr != OFS_CONTROL |=>
        (RDATA & ~IMPL) == 8'h00)
        else $error("reserved read bits set");
    pin_follow_a: assert property (quiet_inputs ##0 pin_read |=>
        (RDATA & 8'h83) == (PIN_IN & IMPL & 8'h83))
        else $error("pin state read differs from pins");
    rsvd_drive_a: assert property ((PIN_OE_N | IMPL) == 8'hff)
        else $error("reserved pin driven");
    cs_five_a: assert property (CHIP_SELECT_FIVE_ON |->
        !PIN_OE_N[PIN_CS5] && !DEBUG_VARIANT)
        else $error("chip select five pin not driven");
    cs_four_a: assert property (CHIP_SELECT_FOUR_ON |->
        !PIN_OE_N[PIN_CS4] && !DEBUG_VARIANT)
        else $error("chip select four pin not driven");
    dbg_off_a: assert property (!DEBUG_VARIANT |-> !TEST_CLOCK && !TEST_MODE_SELECT)
        else $error("scan input active in bus variant");
    manual_reset_in_pin_a: assert property (MANUAL_RESET_IN |->
        PIN_OE_N[PIN_MANUAL_RESET_IN] && !DEBUG_VARIANT)
        else $error("manual reset pin driven");
endmodule

// ### sim/psp_pins.sv
`timescale 1ns/1ns
// Board side: driven pins show the port, others the board level
module psp_pins (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] board,
    output logic [7:0] pin_in
);
    // Wire level per pin from both drivers
    assign pin_in = (pin_out & ~pin_oe_n) | (board & pin_oe_n);
endmodule

// ### sim/psp_port_bench.sv
`timescale 1ns/1ns
module psp_port_bench;
    import psp_pkg::*;
    logic CLK;
    logic NRST;
    psp_bus_type BUS;
    psp_func_type func_in;
    logic [7:0] rdata, pin_in, pin_out, pin_oe_n, board, got;
    logic manual_reset_in, tck, tms, cs5_on, cs4_on;
    logic [7:0] dbg_rdata, dbg_pin_in, dbg_pin_out, dbg_pin_oe_n, got_dbg;
    logic dbg_tck, dbg_tms;
    int error_cnt = 0;
    int num_checks = 0;
    // Free-running clock
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    psp_port #(.DEBUG_VARIANT(1'b0)) psp_port_inst (.CLK(CLK), .NRST(NRST), .BUS(BUS),
        .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
        .FUNC_IN(func_in), .MANUAL_RESET_IN(manual_reset_in), .TEST_CLOCK(tck), .TEST_MODE_SELECT(tms),
        .CHIP_SELECT_FIVE_ON(cs5_on), .CHIP_SELECT_FOUR_ON(cs4_on));
    psp_pins psp_pins_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board(board),
        .pin_in(pin_in));
    // Debug-port variant on the same bus and board
    if (1)
    begin : debug_side
        psp_port #(.DEBUG_VARIANT(1'b1)) psp_port_inst (.CLK(CLK), .NRST(NRST), .BUS(BUS),
            .RDATA(dbg_rdata), .PIN_IN(dbg_pin_in), .PIN_OUT(dbg_pin_out),
            .PIN_OE_N(dbg_pin_oe_n), .FUNC_IN(func_in), .MANUAL_RESET_IN(),
            .TEST_CLOCK(dbg_tck), .TEST_MODE_SELECT(dbg_tms), .CHIP_SELECT_FIVE_ON(),
            .CHIP_SELECT_FOUR_ON());
        psp_pins psp_pins_inst (.pin_out(dbg_pin_out), .pin_oe_n(dbg_pin_oe_n), .board(board),
            .pin_in(dbg_pin_in));
    end
    // Byte compare
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle write strobe
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK);
        BUS <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK);
        BUS.wr <= 1'b0;
    endtask
    // Read strobe, data taken the cycle after
    task rd(input logic [1:0] a);
        @(posedge CLK);
        BUS <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge CLK);
        BUS.rd <= 1'b0;
        #1 got = rdata;
        got_dbg = dbg_rdata;
    endtask
    // Let synchroniser and pin flops land
    task settle;
        repeat (4) @(posedge CLK);
        #1;
    endtask
    task t_after_reset;
        settle;
        rd(OFS_PIN_STATE); chk(got, 8'h12);
        chk(got_dbg, 8'h40);
        rd(OFS_LATCH); chk(got, 8'h00);
        chk(pin_oe_n, 8'hff);
    endtask
    task t_readback;
        board <= 8'h00;
        wr(OFS_PIN_STATE, 8'hff);
        rd(OFS_LATCH); chk(got, 8'h00);
        wr(OFS_LATCH, 8'hff);
        rd(OFS_LATCH); chk(got, 8'h13);
        wr(OFS_DIRECTION, 8'h01);
        settle;
        chk(pin_oe_n, 8'hfe);
        chk({7'h00, pin_out[0]}, 8'h01);
        rd(OFS_PIN_STATE); chk(got, 8'h01);
        board <= 8'h12;
        settle;
        rd(OFS_PIN_STATE); chk(got, 8'h13);
    endtask
    task t_chip_select;
        func_in <= '{1'b1, 1'b0, 1'b0};
        wr(OFS_DIRECTION, 8'h03);
        wr(OFS_CONTROL, 8'h10);
        settle;
        chk({6'h00, cs5_on, cs4_on}, 8'h03);
        chk(pin_out & 8'h03, 8'h02);
        wr(OFS_CONTROL, 8'h18);
        settle;
        chk({6'h00, cs5_on, cs4_on}, 8'h03);
        wr(OFS_CONTROL, 8'h0c);
        settle;
        chk({6'h00, cs5_on, cs4_on}, 8'h00);
        wr(OFS_CONTROL, 8'h1c);
        settle;
        chk({6'h00, cs5_on, cs4_on}, 8'h00);
        chk(pin_out & 8'h03, 8'h03);
        rd(OFS_CONTROL); chk(got, 8'h1c);
        rd(OFS_DIRECTION); chk(got, 8'h00);
    endtask
    task t_manual_reset;
        board <= 8'h10;
        wr(OFS_DIRECTION, 8'h10);
        wr(OFS_CONTROL, 8'h1d);
        settle;
        chk({7'h00, manual_reset_in}, 8'h01);
        chk({7'h00, pin_oe_n[4]}, 8'h01);
        wr(OFS_CONTROL, 8'h1c);
        settle;
        chk({6'h00, manual_reset_in, pin_oe_n[4]}, 8'h00);
    endtask
    // Debug variant: readback, then scan pins over direction bits
    task t_debug_port;
        board <= 8'h40;
        func_in <= '0;
        wr(OFS_DIRECTION, 8'h80);
        settle;
        chk(dbg_pin_oe_n, 8'h7f);
        chk(dbg_pin_out, 8'h80);
        rd(OFS_PIN_STATE); chk(got_dbg, 8'hc0);
        chk(got, 8'h00);
        wr(OFS_DIRECTION, 8'h60);
        board <= 8'h60;
        wr(OFS_CONTROL, 8'h1e);
        settle;
        chk(dbg_pin_oe_n, 8'h7f);
        chk(dbg_pin_out, 8'h00);
        chk({6'h00, dbg_tck, dbg_tms}, 8'h03);
        chk({6'h00, tck, tms}, 8'h00);
        rd(OFS_PIN_STATE); chk(got_dbg, 8'h60);
        func_in <= '{1'b0, 1'b0, 1'b1};
        settle;
        chk(dbg_pin_out, 8'h80);
        wr(OFS_CONTROL, 8'h1c);
        settle;
        chk({6'h00, dbg_tck, dbg_tms}, 8'h00);
        chk(dbg_pin_oe_n, 8'h9f);
    endtask
    // Verdict and end of run
    task end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset then scenarios
    initial
    begin
        NRST = 1'b0;
        BUS = '0;
        func_in = '0;
        board = 8'h5a;
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        t_after_reset;
        t_readback;
        t_chip_select;
        t_manual_reset;
        t_debug_port;
        end_sim;
    end
endmodule
bind psp_port psp_port_properties #(.DEBUG_VARIANT(DEBUG_VARIANT)) psp_port_properties_inst (
    .CLK(CLK), .NRST(NRST), .BUS(BUS), .RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE_N(PIN_OE_N), .FUNC_IN(FUNC_IN), .MANUAL_RESET_IN(MANUAL_RESET_IN),
    .TEST_CLOCK(TEST_CLOCK), .TEST_MODE_SELECT(TEST_MODE_SELECT),
    .CHIP_SELECT_FIVE_ON(CHIP_SELECT_FIVE_ON), .CHIP_SELECT_FOUR_ON(CHIP_SELECT_FOUR_ON));
